//--- verilog/hci_pkg.sv
// Purpose: shared constants, types and command tables of the host command interpreter
// Assumes: mclk at 20 MHz
// Notes:   byte counts exclude the code/status byte and the checksum byte
package hci_pkg;
	// clock and serial timing
	localparam int          CLK_HZ     = 20_000_000;
	localparam int          BAUD_BPS   = 9600;
	localparam int          BIT_CYC    = CLK_HZ / BAUD_BPS;
	// i2c target address and fill byte
	localparam logic [6:0]  I2C_ADDR   = 7'h38;
	localparam logic [7:0]  NOREQ_BYTE = 8'hff;
	localparam logic [7:0]  CKS_TARGET = 8'hff;
	// status byte bit positions
	localparam int          ST_INVALID = 7;
	localparam int          ST_CKS     = 6;
	localparam int          ST_SNACK   = 5;
	localparam int          ST_BUSY    = 4;
	// command codes
	localparam logic [7:0]  CMD_PID    = 8'h00;
	localparam logic [7:0]  CMD_TRK    = 8'h01;
	localparam logic [7:0]  CMD_GMODE  = 8'h10;
	localparam logic [7:0]  CMD_SMODE  = 8'h11;
	localparam logic [7:0]  CMD_HUM    = 8'h12;
	localparam logic [7:0]  CMD_MEAS   = 8'h18;
	localparam logic [7:0]  CMD_CGPIO  = 8'h20;
	localparam logic [7:0]  CMD_GGPIO  = 8'h21;
	localparam logic [7:0]  CMD_SGPIO  = 8'h22;
	localparam logic [7:0]  CMD_CLGPIO = 8'h23;
	localparam logic [7:0]  CMD_RFL    = 8'h40;
	localparam logic [7:0]  CMD_WFLS   = 8'h41;
	localparam logic [7:0]  CMD_WFL    = 8'h42;
	localparam logic [7:0]  CMD_RESET  = 8'h8f;

	// interpreter and i2c target states
	typedef enum logic [0:0] {M_RX = 1'b0, M_RSP = 1'b1} hci_mst_t;
	typedef enum logic [2:0] {
		I_IDLE = 3'b000, I_ADDR = 3'b001, I_AACK = 3'b010, I_WR = 3'b011,
		I_WACK = 3'b100, I_LOAD = 3'b101, I_RD = 3'b110, I_RACK = 3'b111
	} hci_ist_t;

	// {known, request parameter bytes}
	function automatic logic [2:0] hci_req_info(input logic [7:0] c);
		case (c)
			CMD_PID, CMD_TRK, CMD_GMODE, CMD_MEAS, CMD_GGPIO, CMD_WFL, CMD_RESET: return 3'h4;
			CMD_SMODE, CMD_HUM, CMD_CGPIO, CMD_SGPIO, CMD_CLGPIO, CMD_RFL: return 3'h5;
			CMD_WFLS: return 3'h6;
			default: return 3'h0;
		endcase
	endfunction

	// response parameter bytes; measurement length comes from the application
	function automatic logic [3:0] hci_rsp_len(input logic [7:0] c, input logic [3:0] meas);
		case (c)
			CMD_PID: return 4'h5;
			CMD_TRK: return 4'h6;
			CMD_GMODE, CMD_GGPIO, CMD_RFL, CMD_WFL: return 4'h1;
			CMD_MEAS: return meas;
			default: return 4'h0;
		endcase
	endfunction
endpackage

//--- verilog/hci_uart.sv
// Purpose: 8N1 serial receiver and transmitter for the command link
// Assumes: one bit lasts BIT_CYCLES mclk cycles
// Notes:   a byte with a bad stop bit is dropped and flagged; a bad start bit is dropped without a flag
module hci_uart #(
	parameter int BIT_CYCLES = hci_pkg::BIT_CYC
) (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rstn,
	// serial pins
	input  wire logic       rxd,
	output logic            txd,
	// receive side
	output logic [7:0]      rx_byte,
	output logic            rx_stb,
	output logic            rx_ferr,
	// transmit side
	input  wire logic       tx_stb,
	input  wire logic [7:0] tx_byte,
	output logic            tx_busy
);
	import hci_pkg::*;

	initial begin
		if (BIT_CYCLES < 4 || BIT_CYCLES > 4095) $error("hci_uart: BIT_CYCLES out of range");
	end

	localparam logic [11:0] BITN = 12'(BIT_CYCLES - 1);
	localparam logic [11:0] HALF = 12'(BIT_CYCLES / 2);

	typedef struct packed {
		logic        s1, s2, rbusy;
		logic [11:0] rcnt;
		logic [3:0]  rbit;
		logic [7:0]  rsh, rbyte;
		logic        rstb, ferr, tbusy;
		logic [11:0] tcnt;
		logic [3:0]  tbit;
		logic [9:0]  tsh;
		logic        txd;
	} hci_ust_t;

	hci_ust_t s_r, s_nxt;

	// receive and transmit sequencing, one bit period per count-down after the receiver's half-bit start delay
	always_comb begin
		s_nxt      = s_r;
		s_nxt.s1   = rxd;
		s_nxt.s2   = s_r.s1;
		s_nxt.rstb = 1'b0;
		s_nxt.ferr = 1'b0;
		if (!s_r.rbusy) begin
			if (!s_r.s2) begin
				s_nxt.rbusy = 1'b1;
				s_nxt.rcnt  = HALF;
				s_nxt.rbit  = 4'h0;
			end
		end else if (s_r.rcnt != 12'h000) begin
			s_nxt.rcnt = s_r.rcnt - 12'h001;
		end else begin
			s_nxt.rcnt = BITN;
			s_nxt.rbit = s_r.rbit + 4'h1;
			if (s_r.rbit == 4'h0 && s_r.s2) begin
				s_nxt.rbusy = 1'b0; // glitch, not a start bit
			end else if (s_r.rbit == 4'h9) begin
				s_nxt.rbusy = 1'b0;
				s_nxt.rbyte = s_r.rsh;
				s_nxt.rstb  = s_r.s2;
				s_nxt.ferr  = !s_r.s2;
			end else if (s_r.rbit != 4'h0) begin
				s_nxt.rsh = {s_r.s2, s_r.rsh[7:1]}; // lsb first
			end
		end
		// transmit: start, eight data bits, one stop bit, no parity
		if (!s_r.tbusy) begin
			s_nxt.txd = 1'b1;
			if (tx_stb) begin
				s_nxt.tbusy = 1'b1;
				s_nxt.tsh   = {1'b1, tx_byte, 1'b0};
				s_nxt.tcnt  = BITN;
				s_nxt.tbit  = 4'h0;
				s_nxt.txd   = 1'b0;
			end
		end else if (s_r.tcnt != 12'h000) begin
			s_nxt.tcnt = s_r.tcnt - 12'h001;
		end else if (s_r.tbit == 4'h9) begin
			s_nxt.tbusy = 1'b0;
		end else begin
			s_nxt.tcnt = BITN;
			s_nxt.tbit = s_r.tbit + 4'h1;
			s_nxt.tsh  = {1'b1, s_r.tsh[9:1]};
			s_nxt.txd  = s_r.tsh[1];
		end
	end

	// state register
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s_r     <= '0;
			s_r.s1  <= 1'b1;
			s_r.s2  <= 1'b1;
			s_r.txd <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign txd     = s_r.txd;
	assign rx_byte = s_r.rbyte;
	assign rx_stb  = s_r.rstb;
	assign rx_ferr = s_r.ferr;
	assign tx_busy = s_r.tbusy;

	// a taken byte starts with a low start bit and holds the whole byte behind it
	property p_tx_start;
		@(posedge mclk) disable iff (!rstn)
			(tx_stb && !s_r.tbusy) |=> (!txd && s_r.tsh[8:1] == $past(tx_byte));
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("start bit or loaded byte wrong");
endmodule

//--- verilog/hci_top.sv
// Purpose: host command interpreter behind a UART and an I2C target port
// Assumes: application logic answers rsp_data combinationally from rsp_idx
// Notes:   one request is handled at a time; the answer goes back on the request's port
// Overview of operation
// - UART runs 8N1 at 9600 baud without flow control.
// - corrupted frames show as checksum errors, and UART stop bit errors also set status bit 7; no resynchronisation is done on the UART.
// - every accepted request gets a response, except the reset command.
// - frames are code or status byte, parameter bytes, then checksum.
// - checksum is the inverted byte sum; all frame bytes sum to 0xff.
// - I2C start or restart followed by a write discards state for a fresh request.
// - bytes written over I2C beyond the expected length are ignored, except after the reset command, where they start a new request.
// - a short I2C write yields an error in the next response status.
// - an I2C read without a preceding request write returns 0xff bytes.
// - the status byte is the first byte of every response.
// - status bit 7 flags unknown code, orphan read, I2C or UART errors.
// - status bit 6 flags a wrong request checksum.
// - status bit 5 flags an unexpected NACK on the internal sensor bus.
// - status bit 4 flags a retrieval before the asynchronous operation finished.
// - status bits 3 to 0 carry the operation mode error code.
// - command codes and parameter byte counts follow the fixed command table.
// - product id answer holds two id bytes and three firmware bytes.
// - I2C target answers at address 0x38 in standard and fast mode.
module hci_top (
	// clock and reset
	input  wire logic                mclk,
	input  wire logic                rstn,
	// uart pins
	input  wire logic                uart_rxd,
	output logic                     uart_txd,
	// i2c pins, open drain
	input  wire logic                i2c_scl_i,
	output logic                     i2c_scl_o,
	output logic                     i2c_scl_oe,
	input  wire logic                i2c_sda_i,
	output logic                     i2c_sda_o,
	output logic                     i2c_sda_oe,
	// command to the application
	output logic                     cmd_stb,
	output logic [7:0]               cmd_code,
	output logic [7:0]               cmd_par0,
	output logic [7:0]               cmd_par1,
	output logic                     reset_req,
	// response data from the application
	output logic [3:0]               rsp_idx,
	input  wire logic [7:0]          rsp_data,
	input  wire logic [3:0]          meas_len,
	// status sources
	input  wire logic                sensor_nack,
	input  wire logic                async_pending,
	input  wire logic [3:0]          mode_err
);
	import hci_pkg::*;

	typedef struct packed {
		hci_mst_t    m;
		logic        src;  // 1 = request came over i2c
		logic [2:0]  cnt, need;
		logic [7:0]  sum, code, par0, par1;
		logic        pend7;
		logic [7:0]  status;
		logic [3:0]  nrsp;
		logic [4:0]  pos;
		logic [7:0]  rsum, ob;
		logic        ob_vld;
		logic [3:0]  rsp_idx;
		logic        cmd_stb, rst_req, tx_stb;
		logic [7:0]  tx_byte;
		logic        scl1, scl2, scl3, sda1, sda2, sda3;
		hci_ist_t    ist;
		logic [3:0]  bitc;
		logic [7:0]  sh;
		logic        rw, wr_act, sda_oe, scl_oe;
	} hci_st_t;

	hci_st_t    s_r, s_nxt;
	logic [7:0] u_byte;
	logic       u_stb, u_ferr, u_busy;
	logic       i_wrbeg, i_rxstb, i_end, i_take, i_noreq;
	logic [7:0] i_rxd;

	hci_uart #(.BIT_CYCLES(BIT_CYC)) u_uart (
		.mclk    (mclk),
		.rstn    (rstn),
		.rxd     (uart_rxd),
		.txd     (uart_txd),
		.rx_byte (u_byte),
		.rx_stb  (u_stb),
		.rx_ferr (u_ferr),
		.tx_stb  (s_r.tx_stb),
		.tx_byte (s_r.tx_byte),
		.tx_busy (u_busy)
	);

	// i2c target, frame collector and response generator
	always_comb begin
		logic       rise, fall, start, stop, bsrc, bstb, do_ev, ev_short, known, take;
		logic [7:0] b, sum_n, st;
		logic [2:0] info;
		rise     = 1'b0;
		fall     = 1'b0;
		start    = 1'b0;
		stop     = 1'b0;
		bsrc     = 1'b0;
		bstb     = 1'b0;
		do_ev    = 1'b0;
		ev_short = 1'b0;
		known    = 1'b0;
		take     = 1'b0;
		b        = 8'h00;
		sum_n    = 8'h00;
		st       = 8'h00;
		info     = 3'h0;
		s_nxt    = s_r;
		i_wrbeg  = 1'b0;
		i_rxstb  = 1'b0;
		i_rxd    = s_r.sh;
		i_end    = 1'b0;
		i_take   = 1'b0;
		i_noreq  = 1'b0;
		s_nxt.cmd_stb = 1'b0;
		s_nxt.rst_req = 1'b0;
		s_nxt.tx_stb  = 1'b0;
		// pin synchronisers and bus conditions
		s_nxt.scl1 = i2c_scl_i;
		s_nxt.scl2 = s_r.scl1;
		s_nxt.scl3 = s_r.scl2;
		s_nxt.sda1 = i2c_sda_i;
		s_nxt.sda2 = s_r.sda1;
		s_nxt.sda3 = s_r.sda2;
		rise  = s_r.scl2 && !s_r.scl3;
		fall  = !s_r.scl2 && s_r.scl3;
		start = s_r.scl2 && s_r.scl3 && !s_r.sda2 && s_r.sda3;
		stop  = s_r.scl2 && s_r.scl3 && s_r.sda2 && !s_r.sda3;
		if (start || stop) begin
			s_nxt.ist    = start ? I_ADDR : I_IDLE;
			s_nxt.bitc   = 4'h0;
			s_nxt.sda_oe = 1'b0;
			s_nxt.scl_oe = 1'b0;
			s_nxt.wr_act = 1'b0;
			i_end        = s_r.wr_act;
		end else begin
			case (s_r.ist)
				I_ADDR, I_WR: begin
					if (rise) begin
						s_nxt.sh   = {s_r.sh[6:0], s_r.sda2};
						s_nxt.bitc = s_r.bitc + 4'h1;
					end else if (fall && s_r.bitc == 4'h8) begin
						s_nxt.bitc = 4'h0;
						if (s_r.ist == I_WR) begin
							s_nxt.sda_oe = 1'b1;
							s_nxt.ist    = I_WACK;
							i_rxstb      = 1'b1;
						end else if (s_r.sh[7:1] == I2C_ADDR) begin
							s_nxt.sda_oe = 1'b1;
							s_nxt.rw     = s_r.sh[0];
							s_nxt.ist    = I_AACK;
						end else begin
							s_nxt.ist = I_IDLE;
						end
					end
				end
				I_AACK: begin
					if (fall) begin
						s_nxt.sda_oe = 1'b0;
						if (s_r.rw) begin
							s_nxt.ist    = I_LOAD;
							s_nxt.scl_oe = 1'b1;
							i_noreq      = !(s_r.m == M_RSP && s_r.src);
						end else begin
							s_nxt.ist    = I_WR;
							s_nxt.wr_act = 1'b1;
							i_wrbeg      = 1'b1;
						end
					end
				end
				I_WACK: begin
					if (fall) begin
						s_nxt.sda_oe = 1'b0;
						s_nxt.ist    = I_WR;
					end
				end
				I_LOAD: begin
					// clock held low until the next byte is ready
					if (s_r.m == M_RSP && s_r.src) begin
						if (s_r.ob_vld) begin
							s_nxt.sh = s_r.ob;
							i_take   = 1'b1;
						end
					end else begin
						s_nxt.sh = NOREQ_BYTE;
					end
					if (i_take || !(s_r.m == M_RSP && s_r.src)) begin
						s_nxt.ist    = I_RD;
						s_nxt.bitc   = 4'h0;
						s_nxt.scl_oe = 1'b0;
						s_nxt.sda_oe = !s_nxt.sh[7];
					end
				end
				I_RD: begin
					if (fall) begin
						s_nxt.bitc = s_r.bitc + 4'h1;
						if (s_r.bitc == 4'h7) begin
							s_nxt.sda_oe = 1'b0;
							s_nxt.ist    = I_RACK;
						end else begin
							s_nxt.sh     = {s_r.sh[6:0], 1'b0};
							s_nxt.sda_oe = !s_r.sh[6];
						end
					end
				end
				I_RACK: begin
					// a nack ends the read; the host then sends stop
					if (rise) begin
						s_nxt.bitc = 4'h9;
						if (s_r.sda2) s_nxt.ist = I_IDLE;
					end else if (fall && s_r.bitc == 4'h9) begin
						s_nxt.ist    = I_LOAD;
						s_nxt.scl_oe = 1'b1;
					end
				end
				default: ;
			endcase
		end
		// incoming byte, i2c first when both arrive together
		if (i_rxstb) begin
			bstb = 1'b1;
			bsrc = 1'b1;
			b    = i_rxd;
		end else if (u_stb) begin
			bstb = 1'b1;
			b    = u_byte;
		end
		sum_n = 8'(s_r.sum + b);
		if (i_wrbeg) begin
			s_nxt.m      = M_RX;
			s_nxt.cnt    = 3'h0;
			s_nxt.ob_vld = 1'b0;
		end else if (s_r.m == M_RX) begin
			if (i_end && s_r.src && s_r.cnt != 3'h0) begin
				do_ev    = 1'b1;
				ev_short = 1'b1;
			end else if (bstb && (s_r.cnt == 3'h0 || bsrc == s_r.src)) begin
				s_nxt.cnt = 3'(s_r.cnt + 3'h1);
				s_nxt.sum = sum_n;
				if (s_r.cnt == 3'h0) begin
					info       = hci_req_info(b);
					s_nxt.code = b;
					s_nxt.src  = bsrc;
					s_nxt.sum  = b;
					s_nxt.need = 3'({1'b0, info[1:0]} + 3'h1);
				end else begin
					if (s_r.cnt == 3'h1) s_nxt.par0 = b;
					if (s_r.cnt == 3'h2) s_nxt.par1 = b;
					do_ev = (s_r.cnt == s_r.need);
				end
			end
		end else begin
			// response generation; bytes of a new request are ignored meanwhile
			if (!s_r.ob_vld) begin
				s_nxt.ob_vld = 1'b1;
				if (s_r.pos == 5'h00) s_nxt.ob = s_r.status;
				else if (s_r.pos == 5'({1'b0, s_r.nrsp} + 5'h01)) s_nxt.ob = ~s_r.rsum;
				else s_nxt.ob = rsp_data;
			end
			take = s_r.src ? i_take : (!u_busy && !s_r.tx_stb && s_r.ob_vld);
			if (take) begin
				s_nxt.tx_stb  = !s_r.src;
				s_nxt.tx_byte = s_r.ob;
				s_nxt.rsum    = 8'(s_r.rsum + s_r.ob);
				s_nxt.ob_vld  = 1'b0;
				if (s_r.pos == 5'({1'b0, s_r.nrsp} + 5'h01)) begin
					s_nxt.m = M_RX;
				end else begin
					s_nxt.pos     = 5'(s_r.pos + 5'h01);
					s_nxt.rsp_idx = s_r.pos[3:0];
				end
			end
		end
		// frame evaluation: checksum, short write and sticky framing errors are the corruption checks
		if (do_ev) begin
			info  = hci_req_info(s_r.code);
			known = info[2];
			st[ST_INVALID] = !known || ev_short || s_r.pend7;
			st[ST_CKS]     = !ev_short && sum_n != CKS_TARGET;
			st[ST_SNACK]   = sensor_nack;
			st[ST_BUSY]    = async_pending && s_r.code == CMD_MEAS;
			st[3:0]        = mode_err;
			s_nxt.status   = st;
			s_nxt.cnt      = 3'h0;
			s_nxt.pend7    = 1'b0;
			s_nxt.pos      = 5'h00;
			s_nxt.rsum     = 8'h00;
			s_nxt.ob_vld   = 1'b0;
			s_nxt.rsp_idx  = 4'h0;
			s_nxt.nrsp     = (st[7:6] != 2'b00) ? 4'h0 : hci_rsp_len(s_r.code, meas_len);
			s_nxt.cmd_stb  = st[7:6] == 2'b00;
			s_nxt.m        = M_RSP;
			if (st[7:6] == 2'b00 && s_r.code == CMD_RESET) begin
				s_nxt.rst_req = 1'b1;
				s_nxt.m       = M_RX;
			end
		end
		// error events are sticky until reported; setting wins over the clear
		if (u_ferr || i_noreq) s_nxt.pend7 = 1'b1;
	end

	// state register
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s_r      <= '0;
			s_r.scl1 <= 1'b1;
			s_r.scl2 <= 1'b1;
			s_r.scl3 <= 1'b1;
			s_r.sda1 <= 1'b1;
			s_r.sda2 <= 1'b1;
			s_r.sda3 <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs from the state register; the i2c data and clock outputs are tied low
	assign cmd_stb    = s_r.cmd_stb;
	assign cmd_code   = s_r.code;
	assign cmd_par0   = s_r.par0;
	assign cmd_par1   = s_r.par1;
	assign reset_req  = s_r.rst_req;
	assign rsp_idx    = s_r.rsp_idx;
	assign i2c_sda_oe = s_r.sda_oe;
	assign i2c_scl_oe = s_r.scl_oe;
	assign i2c_sda_o  = 1'b0;
	assign i2c_scl_o  = 1'b0;

	// checks
	property p_first_status;
		@(posedge mclk) disable iff (!rstn) $rose(s_r.m == M_RSP) |=> (s_r.ob_vld && s_r.ob == s_r.status);
	endproperty
	a_first_status: assert property (p_first_status) else $error("status not first");
	property p_unknown;
		@(posedge mclk) disable iff (!rstn)
			$rose(s_r.m == M_RSP) && hci_req_info(s_r.code) == 3'h0 |-> s_r.status[ST_INVALID];
	endproperty
	a_unknown: assert property (p_unknown) else $error("unknown code not flagged");
	property p_cks;
		@(posedge mclk) disable iff (!rstn) s_r.status[ST_CKS] && s_r.m == M_RSP |-> s_r.nrsp == 4'h0;
	endproperty
	a_cks: assert property (p_cks) else $error("bad checksum answered with data");
	property p_snack;
		@(posedge mclk) disable iff (!rstn) $rose(s_r.m == M_RSP) |-> s_r.status[ST_SNACK] == $past(sensor_nack);
	endproperty
	a_snack: assert property (p_snack) else $error("sensor nack bit wrong");
	property p_mode;
		@(posedge mclk) disable iff (!rstn) $rose(s_r.m == M_RSP) |-> s_r.status[3:0] == $past(mode_err);
	endproperty
	a_mode: assert property (p_mode) else $error("mode error bits wrong");
	property p_wrclr;
		@(posedge mclk) disable iff (!rstn) i_wrbeg |=> (s_r.m == M_RX && s_r.cnt == 3'h0);
	endproperty
	a_wrclr: assert property (p_wrclr) else $error("write start did not clear");
	property p_extra;
		@(posedge mclk) disable iff (!rstn) s_r.m == M_RSP && i_rxstb |=> $stable(s_r.code) && $stable(s_r.par1);
	endproperty
	a_extra: assert property (p_extra) else $error("extra byte stored");
	property p_short;
		@(posedge mclk) disable iff (!rstn)
			i_end && s_r.m == M_RX && s_r.src && s_r.cnt != 3'h0 |=> s_r.m == M_RSP && s_r.status[ST_INVALID];
	endproperty
	a_short: assert property (p_short) else $error("short write not flagged");
	property p_noreq;
		@(posedge mclk) disable iff (!rstn) s_r.ist == I_LOAD && s_r.m == M_RX |=> s_r.sh == NOREQ_BYTE;
	endproperty
	a_noreq: assert property (p_noreq) else $error("orphan read not 0xff");
	property p_reset;
		@(posedge mclk) disable iff (!rstn) s_r.rst_req |-> s_r.m == M_RX && !s_r.tx_stb ##1 s_r.m == M_RX;
	endproperty
	a_reset: assert property (p_reset) else $error("reset produced a response");
	property p_iface;
		@(posedge mclk) disable iff (!rstn) s_r.tx_stb |-> !s_r.src;
	endproperty
	a_iface: assert property (p_iface) else $error("answer on wrong port");
	property p_sum;
		@(posedge mclk) disable iff (!rstn)
			s_r.m == M_RSP && s_r.ob_vld && s_r.pos == 5'({1'b0, s_r.nrsp} + 5'h01) |-> 8'(s_r.ob + s_r.rsum) == CKS_TARGET;
	endproperty
	a_sum: assert property (p_sum) else $error("response checksum wrong");
	c_rsp: cover property (@(posedge mclk) disable iff (!rstn) $rose(s_r.m == M_RSP));
	c_reset: cover property (@(posedge mclk) disable iff (!rstn) s_r.rst_req);
	c_i2c_take: cover property (@(posedge mclk) disable iff (!rstn) i_take);
	c_uart_tx: cover property (@(posedge mclk) disable iff (!rstn) s_r.tx_stb);
endmodule

//--- tb/hci_host.sv
// Purpose: host controller model on the uart and i2c pins of the interpreter
// Assumes: i2c lines have pull-ups; tasks are entered just after a rising edge
// Notes:   i2c clock is low for 2H cycles and high for H+1; uart bit lasts T cycles
module hci_host #(
	parameter int H = 4,
	parameter int T = hci_pkg::BIT_CYC
) (
	// clock
	input  wire logic mclk,
	// device open drain enables
	input  wire logic scl_oe,
	input  wire logic sda_oe,
	// resolved i2c wires
	output logic      scl,
	output logic      sda,
	// uart pins
	output logic      rxd,
	input  wire logic txd
);
	timeunit 1ns;
	timeprecision 1ns;
	import hci_pkg::*;
	logic pull_scl = 1'b0;
	logic pull_sda = 1'b0;
	initial rxd = 1'b1;
	// wired and of both parties, released lines float high
	assign scl = ~(pull_scl | scl_oe);
	assign sda = ~(pull_sda | sda_oe);
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// release scl, then wait out a stretch by the device
	task automatic rise();
		int k;
		k = 0;
		pull_scl <= 1'b0;
		do begin
			cyc(1);
			k++;
		end while (scl !== 1'b1 && k < 2000);
		cyc(H);
	endtask
	// start works from idle and as a repeated start
	task automatic i2c_start();
		pull_sda <= 1'b0;
		cyc(H);
		rise();
		pull_sda <= 1'b1;
		cyc(H);
		pull_scl <= 1'b1;
		cyc(H);
	endtask
	task automatic i2c_stop();
		pull_sda <= 1'b1;
		cyc(H);
		rise();
		pull_sda <= 1'b0;
		cyc(H);
	endtask
	// one clock with data set mid-low, sampled while high
	task automatic clk_bit(input logic b, output logic s);
		pull_sda <= ~b;
		cyc(H);
		rise();
		s = sda;
		pull_scl <= 1'b1;
		cyc(H);
	endtask
	task automatic i2c_wr(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
		clk_bit(1'b1, s);
		ack = ~s;
	endtask
	// nack on the last byte read
	task automatic i2c_rd(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
		clk_bit(last, s);
	endtask
	// 8n1 frame, lsb first
	task automatic u_send(input logic [7:0] d);
		rxd <= 1'b0;
		cyc(T);
		for (int i = 0; i < 8; i++) begin
			rxd <= d[i];
			cyc(T);
		end
		rxd <= 1'b1;
		cyc(T);
	endtask
	task automatic u_recv(output logic [7:0] d, output logic ok);
		int k;
		k = 0;
		while (txd !== 1'b0 && k < 25 * T) begin
			cyc(1);
			k++;
		end
		cyc(T / 2);
		ok = (txd === 1'b0);
		for (int i = 0; i < 8; i++) begin
			cyc(T);
			d[i] = txd;
		end
		cyc(T);
		ok = ok & (txd === 1'b1);
	endtask
endmodule

//--- tb/hci_top_tb.sv
// Purpose: self-checking bench of the host command interpreter
// Assumes: 20 MHz mclk; host model drives both links
// Notes:   random fields come from an xorshift seeded with 79
module hci_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import hci_pkg::*;
	typedef logic [7:0] hci_bq_t[$];
	// design pins
	logic        mclk = 1'b0, rstn = 1'b0, sensor_nack, async_pending;
	logic        rxd, txd, scl, sda, scl_oe, sda_oe, cmd_stb, reset_req;
	logic [7:0]  cmd_code, cmd_par0, cmd_par1, rsp_data, salt = 8'h00;
	logic [3:0]  rsp_idx, meas_len, mode_err;
	// bench state
	logic [31:0] seed = 32'd79;
	logic [7:0]  s_code, s_p0, s_p1, d;
	logic        a, b;
	hci_bq_t     f;
	int          n_stb = 0, n_rst = 0, n_txd = 0, uart_on = 0, k;
	int          n_errors = 0, total_checks = 0;
	// command table: code, request and response parameter counts
	logic [7:0]  cd [14] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h18, 8'h20,
		8'h21, 8'h22, 8'h23, 8'h40, 8'h41, 8'h42, 8'h8f};
	int          nq [14] = '{0, 0, 0, 1, 1, 0, 1, 0, 1, 1, 1, 2, 0, 0};
	int          nr [14] = '{5, 6, 1, 0, 0, 0, 0, 1, 0, 0, 1, 0, 1, 0};
	always #25 mclk = ~mclk;
	// application answers from the byte index
	assign rsp_data = salt ^ {4'h0, rsp_idx};
	hci_top dut_u (.mclk(mclk), .rstn(rstn), .uart_rxd(rxd), .uart_txd(txd),
		.i2c_scl_i(scl), .i2c_scl_o(), .i2c_scl_oe(scl_oe), .i2c_sda_i(sda),
		.i2c_sda_o(), .i2c_sda_oe(sda_oe), .cmd_stb(cmd_stb), .cmd_code(cmd_code),
		.cmd_par0(cmd_par0), .cmd_par1(cmd_par1), .reset_req(reset_req),
		.rsp_idx(rsp_idx), .rsp_data(rsp_data), .meas_len(meas_len),
		.sensor_nack(sensor_nack), .async_pending(async_pending), .mode_err(mode_err));
	hci_host hst_u (.mclk(mclk), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl),
		.sda(sda), .rxd(rxd), .txd(txd));
	// capture command pulses and stray uart activity
	always @(posedge mclk) begin
		if (cmd_stb === 1'b1) begin
			n_stb <= n_stb + 1;
			s_code <= cmd_code;
			s_p0 <= cmd_par0;
			s_p1 <= cmd_par1;
		end
		if (reset_req === 1'b1)
			n_rst <= n_rst + 1;
		if (rstn && uart_on == 0 && txd !== 1'b1)
			n_txd <= n_txd + 1;
	end
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	// expected status byte
	function automatic logic [7:0] st(input logic [7:0] c, input logic e7, input logic e6);
		return {e7, e6, sensor_nack, c == 8'h18 && async_pending, mode_err};
	endfunction
	// request frame with inverted-sum checksum, optionally spoiled
	function automatic hci_bq_t mk(input logic [7:0] c, input int np, input logic bad);
		hci_bq_t q;
		logic [7:0] s;
		q = {c};
		s = c;
		for (int i = 0; i < np; i++) begin
			q.push_back(rnd());
			s += q[i + 1];
		end
		q.push_back(~s ^ {7'h0, bad});
		return q;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// new random status sources and response data
	task automatic shake();
		mode_err <= 4'(rnd());
		sensor_nack <= 1'(rnd());
		async_pending <= 1'(rnd());
		meas_len <= 4'(rnd() % 8'd9);
		salt <= rnd();
		hst_u.cyc(1);
	endtask
	task automatic send(input hci_bq_t q, input logic stp);
		logic ak;
		hst_u.i2c_start();
		hst_u.i2c_wr({I2C_ADDR, 1'b0}, ak);
		chk(8'(ak), 8'h01);
		for (int i = 0; i < q.size(); i++) hst_u.i2c_wr(q[i], ak);
		if (stp) hst_u.i2c_stop();
	endtask
	task automatic fetch(input logic [7:0] c, input int n, input logic e7, input logic e6);
		logic [7:0] x, s;
		logic ak;
		if (c == 8'h18) n = meas_len;
		if (e7 | e6) n = 0;
		hst_u.i2c_start();
		hst_u.i2c_wr({I2C_ADDR, 1'b1}, ak);
		hst_u.i2c_rd(1'b0, x);
		chk(x, st(c, e7, e6));
		s = x;
		for (int i = 0; i < n; i++) begin
			hst_u.i2c_rd(1'b0, x);
			chk(x, salt ^ 8'(i));
			s += x;
		end
		hst_u.i2c_rd(1'b1, x);
		chk(x, ~s);
		hst_u.i2c_stop();
	endtask
	// main sequence
	initial begin
		mode_err <= 4'h0;
		sensor_nack <= 1'b0;
		async_pending <= 1'b0;
		meas_len <= 4'h0;
		hst_u.cyc(3);
		chk({5'h0, txd, scl_oe, sda_oe}, 8'h04);
		rstn <= 1'b1;
		hst_u.cyc(4);
		// foreign address is left unanswered
		hst_u.i2c_start();
		hst_u.i2c_wr(8'h72, a);
		chk(8'(a), 8'h00);
		hst_u.i2c_stop();
		// read with no request before it
		hst_u.i2c_start();
		hst_u.i2c_wr({I2C_ADDR, 1'b1}, a);
		for (int i = 0; i < 3; i++) begin
			hst_u.i2c_rd(i == 2, d);
			chk(d, NOREQ_BYTE);
		end
		hst_u.i2c_stop();
		// unknown code, status also carries the earlier orphan read
		shake();
		send(mk(8'h55, 0, 0), 1'b1);
		fetch(8'h55, 0, 1'b1, 1'b0);
		// every command with one surplus byte, stop or restart alternating
		for (int i = 0; i < 14; i++) begin
			shake();
			f = mk(cd[i], nq[i], 1'b0);
			f.push_back(rnd());
			k = n_stb;
			send(f, i[0]);
			hst_u.cyc(4);
			chk(8'(n_stb - k), 8'h01);
			chk(s_code, cd[i]);
			if (nq[i] > 0) chk(s_p0, f[1]);
			if (nq[i] > 1) chk(s_p1, f[2]);
			if (cd[i] == 8'h8f) chk(8'(n_rst), 8'h01);
			else fetch(cd[i], nr[i], 1'b0, 1'b0);
		end
		// spoiled checksum
		shake();
		send(mk(8'h11, 1, 1'b1), 1'b1);
		fetch(8'h11, 0, 1'b0, 1'b1);
		// request cut short
		shake();
		f = mk(8'h41, 2, 1'b0);
		send(f[0:1], 1'b1);
		fetch(8'h41, 0, 1'b1, 1'b0);
		// partial read, then restart with a fresh request
		shake();
		send(mk(8'h00, 0, 1'b0), 1'b1);
		hst_u.i2c_start();
		hst_u.i2c_wr({I2C_ADDR, 1'b1}, a);
		hst_u.i2c_rd(1'b1, d);
		send(mk(8'h21, 0, 1'b0), 1'b0);
		fetch(8'h21, 1, 1'b0, 1'b0);
		chk(8'(n_txd), 8'h00);
		// uart request with a wrong checksum
		shake();
		uart_on = 1;
		fork
			begin
				hst_u.u_send(8'h10);
				hst_u.u_send(8'h42);
			end
			begin
				hst_u.u_recv(d, a);
				chk(d, st(8'h10, 1'b0, 1'b1));
				hst_u.u_recv(d, b);
				chk(d, ~st(8'h10, 1'b0, 1'b1));
				chk({6'h0, a, b}, 8'h03);
			end
		join
		complete_run();
	end
	// watchdog
	initial begin
		#6_000_000;
		n_errors++;
		complete_run();
	end
endmodule
